/* fcsp_defines.svh */
// Register offsets, field positions, reset values and command codes
`ifndef FCSP_DEFINES_SVH
`define FCSP_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FCSP_OFF_DIV      5'h00
`define FCSP_OFF_CNFG     5'h03
`define FCSP_OFF_PROT     5'h04
`define FCSP_OFF_STAT     5'h05
`define FCSP_OFF_CMD      5'h06
`define FCSP_OFF_IRQ_STAT 5'h10
`define FCSP_OFF_IRQ_MASK 5'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FCSP_BIT_BUFFER_EMPTY_FLAG    7
`define FCSP_BIT_COMMAND_COMPLETE_FLAG     6
`define FCSP_BIT_PROTECTION_VIOLATION_FLAG    5
`define FCSP_BIT_ACCESS_ERROR_FLAG   4
`define FCSP_BIT_BLANK    2
`define FCSP_BIT_FAIL     1
`define FCSP_BIT_DONE     0
`define FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE    7
`define FCSP_BIT_COMPLETE_IRQ_ENABLE     6
`define FCSP_BIT_DIVLD    7
`define FCSP_CMD_MASK     8'h65

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FCSP_CMD_VERIFY   8'h05
`define FCSP_CMD_PROGRAM  8'h20
`define FCSP_CMD_SECTOR   8'h40
`define FCSP_CMD_MASS     8'h41

// ----------------------------------------------------------------
// Protection scenarios
// ----------------------------------------------------------------
`define FCSP_PROT_RESET   3'h7
`define FCSP_PROT_FROM7   8'hFF
`define FCSP_PROT_FROM6   8'h5A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FCSP_IRQ_RESET    8'h00

`endif

/* fcsp_pkg.sv */
// Types shared by the flash command status and protection block
package fcsp_pkg;

    typedef enum logic [1:0] {
        FCSP_SEQ_IDLE,
        FCSP_SEQ_ADDR,
        FCSP_SEQ_CMD
    } fcsp_seq_t;

    typedef struct packed {
        fcsp_seq_t  seq;
        logic       buffer_empty_flag;
        logic       command_complete_flag;
        logic       protection_violation_flag;
        logic       access_error_flag;
        logic       blank;
        logic       fail;
        logic       active;
        logic       pending;
        logic       hit;
        logic       start;
        logic       div_written;
        logic       buffer_empty_irq_enable;
        logic       complete_irq_enable;
        logic [7:0] buf_cmd;
        logic [7:0] act_cmd;
        logic [7:0] pend_cmd;
        logic [7:0] rdata;
    } fcsp_state_t;

    typedef struct packed {
        logic [7:0] stat;
        logic [7:0] mask;
    } fcsp_irq_state_t;

    typedef struct packed {
        logic [2:0] scen;
    } fcsp_prot_state_t;

endpackage

/* fcsp_prot_filter.sv */
// Protection scenario register with one-way transition filter
`include "fcsp_defines.svh"

module fcsp_prot_filter (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Write request
    input  wire logic       wr_in,
    input  wire logic [2:0] target_in,
    // Scenario in force
    output logic [2:0]      scen_out
);

    fcsp_pkg::fcsp_prot_state_t state_reg;
    fcsp_pkg::fcsp_prot_state_t state_next;
    logic                       allowed;

    // Rows other than 6 and 7 only keep the present scenario
    function automatic logic fcsp_allowed(input logic [2:0] from_s,
                                          input logic [2:0] to_s);
        logic [7:0] row;
        row = 8'h00;
        if (from_s == 3'h7) begin
            row = `FCSP_PROT_FROM7;
        end else if (from_s == 3'h6) begin
            row = `FCSP_PROT_FROM6;
        end
        return row[to_s] || (from_s == to_s);
    endfunction

    always_comb begin
        state_next = state_reg;
        allowed = fcsp_allowed(state_reg.scen, target_in);
        if (wr_in && allowed) begin
            state_next.scen = target_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.scen <= `FCSP_PROT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign scen_out = state_reg.scen;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_prot_refused_hold: assert property (
        wr_in && !allowed |=> scen_out == $past(scen_out))
        else $error("refused scenario write changed protection");
    chk_prot_accepted_take: assert property (
        wr_in && allowed |=> scen_out == $past(target_in))
        else $error("allowed scenario write not taken");

endmodule

/* fcsp_irq_unit.sv */
// Sticky interrupt status, mask and single level interrupt output
`include "fcsp_defines.svh"

module fcsp_irq_unit #(
    parameter int N_EV = 4
) (
    // Clock and reset
    input  wire logic            core_clk_in,
    input  wire logic            rst_b_in,
    // Events and register access
    input  wire logic [N_EV-1:0] event_in,
    input  wire logic            stat_rd_in,
    input  wire logic            mask_wr_in,
    input  wire logic [7:0]      wdata_in,
    // Status
    output logic [7:0]           stat_out,
    output logic [7:0]           mask_out,
    output logic                 irq_out
);

    fcsp_pkg::fcsp_irq_state_t state_reg;
    fcsp_pkg::fcsp_irq_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (stat_rd_in) begin
            state_next.stat = 8'h00;
        end
        // Set after clear so an event in the read cycle survives
        state_next.stat[N_EV-1:0] = state_next.stat[N_EV-1:0] | event_in;
        if (mask_wr_in) begin
            state_next.mask = {{(8-N_EV){1'b0}}, wdata_in[N_EV-1:0]};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.stat <= `FCSP_IRQ_RESET;
            state_reg.mask <= `FCSP_IRQ_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stat_out = state_reg.stat;
    assign mask_out = state_reg.mask;
    assign irq_out  = |(state_reg.stat & state_reg.mask);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_irq_event_sticky: assert property (
        |event_in |=> |stat_out)
        else $error("event lost in interrupt status");

endmodule

/* fcsp_top.sv */
// Flash command status, launch filtering and protection update
//
// Local design decision: strobed register access.
`include "fcsp_defines.svh"

// Overview of operation
// - Protection writes only strengthen; disallowed scenario changes are dropped
// - Protection readback always equals the scenario in force
// - Normal modes: fail and done read zero; complete and blank read-only
// - Special modes: fail is read/write-one-clear, done read-only
// - Buffer-empty flag shows free buffers; writing one launches, and clears it only when the command must wait as pending
// - Writing zero to buffer-empty mid sequence aborts and sets access error
// - Buffer-empty flag with its enable raises the interrupt
// - Complete flag clear while busy, sets only when nothing pending
// - Complete flag with its enable raises the interrupt
// - Program or erase on protected area sets violation; write one clears
// - No launch while violation, access error or fail is set
// - Sequence violation, illegal code or stop while busy set access error
// - Blank sets on erased verify, clears on next valid launch
// - Special modes: fail sets when verify finds array not erased
// - Special modes: done reads zero while an operation is active
// - Only verify, program, sector and mass erase codes are valid
// - Unwritten divider register blocks execution and sets access error
module fcsp_top (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Register port
    input  wire logic [4:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    // Array side and mode
    input  wire logic       array_wr_in,
    input  wire logic       prot_hit_in,
    input  wire logic       special_mode_in,
    input  wire logic       stop_in,
    // Command engine
    input  wire logic       exec_done_in,
    input  wire logic       exec_blank_in,
    output logic            exec_start_out,
    output logic [7:0]      exec_cmd_out,
    // Protection and interrupt
    output logic [2:0]      prot_scenario_out,
    output logic            irq_out
);

    fcsp_pkg::fcsp_state_t s_reg;
    fcsp_pkg::fcsp_state_t s_next;

    logic       wr_stat;
    logic       wr_cmd;
    logic       launch_wr;
    logic       abort_wr;
    logic       errs_set;
    logic       done_now;
    logic [7:0] stat_view;
    logic [3:0] irq_events;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic       irq_sticky;
    logic [2:0] scen;

    function automatic logic fcsp_cmd_valid(input logic [7:0] c);
        return (c == `FCSP_CMD_VERIFY) || (c == `FCSP_CMD_PROGRAM) ||
               (c == `FCSP_CMD_SECTOR) || (c == `FCSP_CMD_MASS);
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign wr_stat   = wr_in && (addr_in == `FCSP_OFF_STAT);
    assign wr_cmd    = wr_in && (addr_in == `FCSP_OFF_CMD);
    assign launch_wr = wr_stat && wdata_in[`FCSP_BIT_BUFFER_EMPTY_FLAG];
    assign abort_wr  = wr_stat && !wdata_in[`FCSP_BIT_BUFFER_EMPTY_FLAG];
    assign errs_set  = s_reg.protection_violation_flag || s_reg.access_error_flag || s_reg.fail;
    assign done_now  = !s_reg.active;

    // ----------------------------------------------------------------
    // Status view
    // ----------------------------------------------------------------
    always_comb begin
        stat_view = 8'h00;
        stat_view[`FCSP_BIT_BUFFER_EMPTY_FLAG]  = s_reg.buffer_empty_flag;
        stat_view[`FCSP_BIT_COMMAND_COMPLETE_FLAG]   = s_reg.command_complete_flag;
        stat_view[`FCSP_BIT_PROTECTION_VIOLATION_FLAG]  = s_reg.protection_violation_flag;
        stat_view[`FCSP_BIT_ACCESS_ERROR_FLAG] = s_reg.access_error_flag;
        stat_view[`FCSP_BIT_BLANK]  = s_reg.blank;
        if (special_mode_in) begin
            stat_view[`FCSP_BIT_FAIL] = s_reg.fail;
            stat_view[`FCSP_BIT_DONE] = done_now;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.start = 1'b0;
        s_next.rdata = 8'h00;

        // Clears come first so that a set in the same cycle wins
        if (wr_stat) begin
            if (wdata_in[`FCSP_BIT_PROTECTION_VIOLATION_FLAG]) begin
                s_next.protection_violation_flag = 1'b0;
            end
            if (wdata_in[`FCSP_BIT_ACCESS_ERROR_FLAG]) begin
                s_next.access_error_flag = 1'b0;
            end
            if (special_mode_in && wdata_in[`FCSP_BIT_FAIL]) begin
                s_next.fail = 1'b0;
            end
        end
        if (wr_in && (addr_in == `FCSP_OFF_DIV)) begin
            s_next.div_written = 1'b1;
        end
        if (wr_in && (addr_in == `FCSP_OFF_CNFG)) begin
            s_next.buffer_empty_irq_enable = wdata_in[`FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE];
            s_next.complete_irq_enable  = wdata_in[`FCSP_BIT_COMPLETE_IRQ_ENABLE];
        end

        // Completion of the active command
        if (exec_done_in && s_reg.active) begin
            if (s_reg.act_cmd == `FCSP_CMD_VERIFY) begin
                if (exec_blank_in) begin
                    s_next.blank = 1'b1;
                end else if (special_mode_in) begin
                    s_next.fail = 1'b1;
                end
            end
            if (s_reg.pending) begin
                // Fetching the pending command keeps complete low
                s_next.act_cmd = s_reg.pend_cmd;
                s_next.pending = 1'b0;
                s_next.buffer_empty_flag   = 1'b1;
                s_next.start   = 1'b1;
            end else begin
                s_next.active = 1'b0;
            end
        end

        // Command write sequence
        unique case (s_reg.seq)
            fcsp_pkg::FCSP_SEQ_IDLE: begin
                if (array_wr_in && s_reg.buffer_empty_flag) begin
                    s_next.seq = fcsp_pkg::FCSP_SEQ_ADDR;
                    s_next.hit = prot_hit_in;
                end else if (wr_cmd) begin
                    s_next.access_error_flag = 1'b1;
                end
            end
            fcsp_pkg::FCSP_SEQ_ADDR: begin
                if (wr_cmd) begin
                    s_next.buf_cmd = wdata_in & `FCSP_CMD_MASK;
                    s_next.seq     = fcsp_pkg::FCSP_SEQ_CMD;
                end else if (array_wr_in || wr_stat) begin
                    s_next.access_error_flag = 1'b1;
                    s_next.seq    = fcsp_pkg::FCSP_SEQ_IDLE;
                end
            end
            fcsp_pkg::FCSP_SEQ_CMD: begin
                if (launch_wr) begin
                    s_next.seq = fcsp_pkg::FCSP_SEQ_IDLE;
                    if (errs_set) begin
                        s_next.seq = fcsp_pkg::FCSP_SEQ_IDLE;
                    end else if (!fcsp_cmd_valid(s_reg.buf_cmd)) begin
                        s_next.access_error_flag = 1'b1;
                    end else if (!s_reg.div_written) begin
                        s_next.access_error_flag = 1'b1;
                    end else if (s_reg.hit &&
                                 s_reg.buf_cmd != `FCSP_CMD_VERIFY) begin
                        s_next.protection_violation_flag = 1'b1;
                    end else begin
                        s_next.blank = 1'b0;
                        if (!s_next.active) begin
                            s_next.active  = 1'b1;
                            s_next.act_cmd = s_reg.buf_cmd;
                            s_next.start   = 1'b1;
                        end else begin
                            s_next.pending  = 1'b1;
                            s_next.pend_cmd = s_reg.buf_cmd;
                            s_next.buffer_empty_flag    = 1'b0;
                        end
                    end
                end else if (abort_wr || array_wr_in || wr_cmd) begin
                    s_next.access_error_flag = 1'b1;
                    s_next.seq    = fcsp_pkg::FCSP_SEQ_IDLE;
                end
            end
            // Unused fourth code falls back to idle
            default: begin
                s_next.seq = fcsp_pkg::FCSP_SEQ_IDLE;
            end
        endcase

        if (stop_in && s_next.active) begin
            s_next.access_error_flag = 1'b1;
        end
        // Complete low whenever anything is active or waiting
        s_next.command_complete_flag = !s_next.active && !s_next.pending;

        if (rd_in) begin
            unique case (addr_in)
                `FCSP_OFF_DIV: begin
                    s_next.rdata[`FCSP_BIT_DIVLD] = s_reg.div_written;
                end
                `FCSP_OFF_CNFG: begin
                    s_next.rdata[`FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE] = s_reg.buffer_empty_irq_enable;
                    s_next.rdata[`FCSP_BIT_COMPLETE_IRQ_ENABLE]  = s_reg.complete_irq_enable;
                end
                `FCSP_OFF_PROT:     s_next.rdata = {5'h00, scen};
                `FCSP_OFF_STAT:     s_next.rdata = stat_view;
                `FCSP_OFF_CMD:      s_next.rdata = s_reg.buf_cmd;
                `FCSP_OFF_IRQ_STAT: s_next.rdata = irq_stat;
                `FCSP_OFF_IRQ_MASK: s_next.rdata = irq_mask;
                default:            s_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg             <= '0;
            s_reg.seq         <= fcsp_pkg::FCSP_SEQ_IDLE;
            s_reg.buffer_empty_flag       <= 1'b1;
            s_reg.command_complete_flag        <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    fcsp_prot_filter u_prot (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_in       (wr_in && (addr_in == `FCSP_OFF_PROT)),
        .target_in   (wdata_in[2:0]),
        .scen_out    (scen)
    );

    assign irq_events = {s_next.access_error_flag && !s_reg.access_error_flag,
                         s_next.protection_violation_flag  && !s_reg.protection_violation_flag,
                         s_next.command_complete_flag   && !s_reg.command_complete_flag,
                         s_next.buffer_empty_flag  && !s_reg.buffer_empty_flag};

    fcsp_irq_unit #(
        .N_EV (4)
    ) u_irq (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .event_in    (irq_events),
        .stat_rd_in  (rd_in && (addr_in == `FCSP_OFF_IRQ_STAT)),
        .mask_wr_in  (wr_in && (addr_in == `FCSP_OFF_IRQ_MASK)),
        .wdata_in    (wdata_in),
        .stat_out    (irq_stat),
        .mask_out    (irq_mask),
        .irq_out     (irq_sticky)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata_out         = s_reg.rdata;
    assign exec_start_out    = s_reg.start;
    assign exec_cmd_out      = s_reg.act_cmd;
    assign prot_scenario_out = scen;
    // Level terms need no clear; they follow the flags
    assign irq_out = irq_sticky ||
                     (s_reg.buffer_empty_flag && s_reg.buffer_empty_irq_enable) ||
                     (s_reg.command_complete_flag && s_reg.complete_irq_enable);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence seq_cmd_loaded;
        s_reg.seq == fcsp_pkg::FCSP_SEQ_CMD && !errs_set;
    endsequence

    chk_abort_sets_err: assert property (
        s_reg.seq != fcsp_pkg::FCSP_SEQ_IDLE && abort_wr |=> s_reg.access_error_flag)
        else $error("abort did not set access error");
    chk_idle_w0_quiet: assert property (
        s_reg.seq == fcsp_pkg::FCSP_SEQ_IDLE && abort_wr && !wdata_in[4]
        && !stop_in |=> $stable(s_reg.access_error_flag))
        else $error("zero write outside sequence set access error");
    chk_command_complete_flag_follow: assert property (
        !s_reg.buffer_empty_flag |-> !s_reg.command_complete_flag)
        else $error("complete set while buffers full");
    chk_refuse_launch: assert property (
        s_reg.seq == fcsp_pkg::FCSP_SEQ_CMD && errs_set && launch_wr
        |=> !exec_start_out || $past(exec_done_in))
        else $error("command launched with an error flag set");
    chk_bad_cmd_err: assert property (
        seq_cmd_loaded ##0 (launch_wr && !fcsp_cmd_valid(s_reg.buf_cmd))
        |=> s_reg.access_error_flag)
        else $error("illegal command did not set access error");
    chk_div_unloaded: assert property (
        seq_cmd_loaded ##0 (launch_wr && !s_reg.div_written)
        |=> s_reg.access_error_flag && !exec_start_out)
        else $error("command ran with divider unwritten");
    chk_irq_buf_empty: assert property (
        s_reg.buffer_empty_flag && s_reg.buffer_empty_irq_enable |-> irq_out)
        else $error("buffer empty interrupt missing");
    chk_irq_complete: assert property (
        s_reg.command_complete_flag && s_reg.complete_irq_enable |-> irq_out)
        else $error("complete interrupt missing");
    chk_stop_err: assert property (
        stop_in && s_reg.active && !exec_done_in |=> s_reg.access_error_flag)
        else $error("stop while busy did not set access error");
    chk_stat_normal_rd: assert property (
        rd_in && addr_in == `FCSP_OFF_STAT && !special_mode_in
        |=> rdata_out[1:0] == 2'h0 && rdata_out[3] == 1'b0)
        else $error("normal mode status shows hidden bits");
    chk_done_read: assert property (
        rd_in && addr_in == `FCSP_OFF_STAT && special_mode_in
        |=> rdata_out[0] == $past(done_now))
        else $error("done bit does not reflect activity");
    chk_prot_readback: assert property (
        rd_in && addr_in == `FCSP_OFF_PROT |=> rdata_out[2:0] == $past(scen))
        else $error("protection readback differs from scenario");

endmodule

/* fcsp_engine_model.sv */
// Behavioural command engine on the far side of the launch port
module fcsp_engine_model (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Launch and test controls
    input  wire logic       start_in,
    input  wire logic [7:0] lat_in,
    input  wire logic       blank_in,
    // Results
    output logic            done_out,
    output logic            blank_out
);
    logic [7:0] cnt_reg;
    logic       busy_reg;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                busy_reg <= 1'b1;
                cnt_reg  <= lat_in;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                done_out <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
    // Result valid only beside done; inverted so stale reads show
    assign blank_out = done_out ? blank_in : ~blank_in;
endmodule

/* tb_flash_cmd_status_protect.sv */
// Self-checking bench for the flash status and protection block
module tb_flash_cmd_status_protect;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, awr = 0, hit = 0;
    logic spc = 0, stp = 0, bsel = 0, rd_seen = 0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wd = 8'h00, lat = 8'h02, rdata, cmd;
    logic [7:0] eq[$], mq[$], cq[$];
    logic [2:0] scen;
    logic start, done, blank, irq;
    int n_errors = 0, num_checks = 0, seed = 15;
    logic [7:0] tg[5] = '{8'h06, 8'h02, 8'h03, 8'h07, 8'h01};
    logic [7:0] ex[5] = '{8'h06, 8'h06, 8'h03, 8'h03, 8'h03};
    logic [7:0] codes[4] = '{8'h05, 8'h20, 8'h40, 8'h41};
    always #20 clk = ~clk;
    fcsp_top DUT (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .array_wr_in(awr), .prot_hit_in(hit), .special_mode_in(spc),
        .stop_in(stp), .exec_done_in(done), .exec_blank_in(blank),
        .exec_start_out(start), .exec_cmd_out(cmd),
        .prot_scenario_out(scen), .irq_out(irq));
    fcsp_engine_model ENG (.core_clk_in(clk), .rst_b_in(rst_b),
        .start_in(start), .lat_in(lat), .blank_in(bsel),
        .done_out(done), .blank_out(blank));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic w(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [4:0] a, input logic [7:0] e,
                     input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        eq.push_back(e);
        mq.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic arr(input logic h);
        @(posedge clk);
        awr <= 1'b1;
        hit <= h;
        @(posedge clk);
        awr <= 1'b0;
    endtask
    task automatic seq(input logic [7:0] c, input logic h, input logic go);
        arr(h);
        w(5'h06, c);
        if (go) cq.push_back(c);
        w(5'h05, 8'h80);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        repeat (2) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) chk("rdata", eq.pop_front(), rdata & mq.pop_front());
        if (start === 1'b1) begin
            if (cq.size() == 0) chk("start", 8'h00, 8'h01);
            else chk("cmd", cq.pop_front(), cmd);
        end
    end
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        chk("scen", 8'h07, {5'h00, scen});
        chk("irq", 8'h00, {7'h00, irq});
        r(5'h05, 8'hC0, 8'hFF);
        r(5'h1F, 8'h00, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            w(5'h04, tg[i]);
            r(5'h04, ex[i], 8'h07);
            chk("scen", ex[i], {5'h00, scen});
        end
        seq(8'h20, 1'b0, 1'b0);
        r(5'h05, 8'h10, 8'h10);
        w(5'h05, 8'h10);
        r(5'h05, 8'h00, 8'h10);
        w(5'h00, 8'h05);
        w(5'h03, 8'hC0);
        w(5'h11, 8'hFF);
        chk("irq", 8'h01, {7'h00, irq});
        for (int i = 0; i < 4; i++) begin
            bsel <= 1'($random(seed));
            seq(codes[i], 1'b0, 1'b1);
            wait_idle();
            r(5'h05, {5'h18, codes[i] == 8'h05 && bsel, 2'h0}, 8'hFF);
            r(5'h10, 8'h02, 8'h02);
        end
        r(5'h10, 8'h00, 8'h02);
        seq(8'h01, 1'b0, 1'b0);
        r(5'h05, 8'h10, 8'h10);
        w(5'h05, 8'h10);
        seq(8'h20, 1'b1, 1'b0);
        r(5'h05, 8'h20, 8'h20);
        seq(8'h20, 1'b0, 1'b0);
        r(5'h05, 8'h20, 8'h30);
        w(5'h05, 8'h20);
        r(5'h05, 8'h00, 8'h20);
        arr(1'b0);
        w(5'h05, 8'h00);
        r(5'h05, 8'h10, 8'h10);
        w(5'h05, 8'h10);
        w(5'h05, 8'h00);
        r(5'h05, 8'h80, 8'h90);
        spc <= 1'b1;
        lat <= 8'h14;
        bsel <= 1'b0;
        r(5'h05, 8'hC1, 8'hFF);
        seq(8'h05, 1'b0, 1'b1);
        r(5'h05, 8'h00, 8'h41);
        wait_idle();
        r(5'h05, 8'h03, 8'h03);
        seq(8'h20, 1'b0, 1'b0);
        w(5'h05, 8'h02);
        r(5'h05, 8'h01, 8'h03);
        seq(8'h20, 1'b0, 1'b1);
        @(posedge clk);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        wait_idle();
        r(5'h05, 8'h10, 8'h10);
        w(5'h05, 8'h10);
        spc <= 1'b0;
        seq(8'h40, 1'b0, 1'b1);
        seq(8'h41, 1'b0, 1'b1);
        r(5'h05, 8'h00, 8'hC0);
        wait_idle();
        wait_idle();
        r(5'h05, 8'hC0, 8'hFF);
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule
